// ### secure_otp_and_block_lock_cmds_tb.sv
// self-checking bench for the security register and block lock commands
`timescale 1ns/1ns
`include "sol_defs.svh"
module secure_otp_and_block_lock_cmds_tb;
   logic core_clk, rst, spi_sck, spi_cs_n, serial_in, serial_out;
   logic serial_out_en, per_block_protect_select, legacy_range_protect;
   logic array_block_locked, busy, write_enable_latch, en;
   logic [2:0] otp_register_locks;
   logic [7:0] query_block;
   logic [15:0] rd;
   int num_errors, checks;

   // long erase so a read can land inside it
   sol_cmd_core #(.ERASE_CYCLES(250), .PROG_CYCLES(20)) uut (
      .core_clk(core_clk), .rst(rst), .spi_sck(spi_sck),
      .spi_cs_n(spi_cs_n), .serial_in(serial_in), .serial_out(serial_out),
      .serial_out_en(serial_out_en),
      .otp_register_locks(otp_register_locks),
      .per_block_protect_select(per_block_protect_select),
      .legacy_range_protect(legacy_range_protect),
      .query_block(query_block), .array_block_locked(array_block_locked),
      .busy(busy), .write_enable_latch(write_enable_latch)
   );
   sol_host_model u_host (
      .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .serial_in(serial_in),
      .serial_out(serial_out), .serial_out_en(serial_out_en)
   );
   initial core_clk = 1'b0;
   always #2 core_clk = ~core_clk;
   //----------
   // helpers
   //----------
   task automatic stop_test();
      if (num_errors == 0 && checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input string name, input logic [15:0] exp,
      input logic [15:0] got);
      checks++;
      if (got !== exp)
      begin
         $display("Error %s expected %h seen %h", name, exp, got);
         num_errors++;
      end
   endtask
   task automatic setin(input logic [2:0] lk, input logic ps,
      input logic lg, input logic [7:0] qb);
      @(negedge core_clk);
      otp_register_locks = lk;
      per_block_protect_select = ps;
      legacy_range_protect = lg;
      query_block = qb;
   endtask
   task automatic view(input logic [2:0] lk, input logic ps,
      input logic lg, input logic [7:0] qb, input logic exp);
      setin(lk, ps, lg, qb);
      repeat (3) @(negedge core_clk);
      chk("block_locked", {15'h0, exp}, {15'h0, array_block_locked});
   endtask
   task automatic cmd(input logic [7:0] op, input logic [23:0] a,
      input int n, input logic [15:0] wd);
      u_host.frame(op, a, n, wd, rd, en);
      @(negedge core_clk);
   endtask
   task automatic rdchk(input logic [7:0] op, input logic [23:0] a,
      input int n, input logic [15:0] exp);
      cmd(op, a, n, 16'h5a5a);
      chk("read_data", exp, rd);
   endtask
   task automatic wait_idle();
      int i;
      i = 0;
      while (busy !== 1'b0 && i < 400)
      begin
         @(negedge core_clk);
         i++;
      end
      if (busy !== 1'b0)
      begin
         $display("Error busy expected 0 seen %b", busy);
         num_errors++;
         stop_test();
      end
   endtask
   //----------
   // scenarios
   //----------
   task automatic t_locks();
      view(3'h0, 1'b1, 1'b0, 8'hff, 1'b1);
      rdchk(`SOL_OP_SFDP, 24'h000002, 56, 16'h4450);
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_UNLOCK, 24'h120000, 32, 16'h0);
      view(3'h0, 1'b1, 1'b0, 8'h12, 1'b0);
      rdchk(`SOL_OP_RDLOCK, 24'h120000, 40, 16'hff00);
      view(3'h0, 1'b0, 1'b1, 8'h12, 1'b1);
      view(3'h0, 1'b0, 1'b0, 8'h13, 1'b0);
      cmd(`SOL_OP_LOCK, 24'h120000, 32, 16'h0);
      view(3'h0, 1'b1, 1'b0, 8'h12, 1'b1);
      rdchk(`SOL_OP_RDLOCK, 24'h120000, 40, 16'hff01);
      cmd(`SOL_OP_WRDI, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_UNLOCK, 24'h120000, 32, 16'h0);
      view(3'h0, 1'b1, 1'b0, 8'h12, 1'b1);
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_UNLOCK, 24'h120000, 32, 16'h0);
      cmd(`SOL_OP_RSTEN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_RST, 24'h0, 8, 16'h0);
      view(3'h0, 1'b1, 1'b0, 8'h12, 1'b0);
      chk("wel", 16'h1, {15'h0, write_enable_latch});
      cmd(`SOL_OP_RSTEN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_RST, 24'h0, 8, 16'h0);
      view(3'h0, 1'b1, 1'b0, 8'h12, 1'b1);
      chk("wel", 16'h0, {15'h0, write_enable_latch});
   endtask
   task automatic t_otp();
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_PROG, 24'h0010ff, 48, 16'ha55a);
      chk("busy", 16'h1, {15'h0, busy});
      wait_idle();
      chk("wel", 16'h0, {15'h0, write_enable_latch});
      rdchk(`SOL_OP_READ, 24'h0010ff, 56, 16'ha55a);
      cmd(`SOL_OP_ERASE, 24'h001000, 32, 16'h0);
      chk("busy", 16'h0, {15'h0, busy});
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_ERASE, 24'h001000, 33, 16'h0);
      chk("busy", 16'h0, {15'h0, busy});
      setin(3'h1, 1'b1, 1'b0, 8'h00);
      cmd(`SOL_OP_ERASE, 24'h001000, 32, 16'h0);
      chk("busy", 16'h0, {15'h0, busy});
      setin(3'h0, 1'b1, 1'b0, 8'h00);
      rdchk(`SOL_OP_READ, 24'h0010ff, 56, 16'ha55a);
      cmd(`SOL_OP_ERASE, 24'h001000, 32, 16'h0);
      chk("busy", 16'h1, {15'h0, busy});
      cmd(`SOL_OP_READ, 24'h001000, 56, 16'h0);
      chk("read_en", 16'h0, {15'h0, en});
      wait_idle();
      chk("wel", 16'h0, {15'h0, write_enable_latch});
      rdchk(`SOL_OP_READ, 24'h0010ff, 56, 16'hffff);
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_PROG, 24'h003040, 48, 16'h1234);
      wait_idle();
      setin(3'h4, 1'b1, 1'b0, 8'h00);
      cmd(`SOL_OP_WREN, 24'h0, 8, 16'h0);
      cmd(`SOL_OP_PROG, 24'h003040, 48, 16'h0000);
      chk("busy", 16'h0, {15'h0, busy});
      setin(3'h0, 1'b1, 1'b0, 8'h00);
      rdchk(`SOL_OP_READ, 24'h003040, 56, 16'h1234);
      rdchk(`SOL_OP_READ, 24'h002040, 56, 16'hffff);
      rdchk(`SOL_OP_READ, 24'h013040, 56, 16'hffff);
   endtask
   initial
   begin
      num_errors = 0;
      checks = 0;
      rst = 1'b1;
      otp_register_locks = 3'h0;
      per_block_protect_select = 1'b1;
      legacy_range_protect = 1'b0;
      query_block = 8'h00;
      repeat (16) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("busy", 16'h0, {15'h0, busy});
      t_locks();
      t_otp();
      stop_test();
   end
endmodule // secure_otp_and_block_lock_cmds_tb

// ### sol_cmd_core.sv
// security register, parameter table and block lock command handling
`timescale 1ns/1ns
`include "sol_defs.svh"

module sol_cmd_core #(
   parameter int ERASE_CYCLES =
      (`SOL_ERASE_TIME_NS + `SOL_CORE_PERIOD_NS - 1) / `SOL_CORE_PERIOD_NS,
   parameter int PROG_CYCLES =
      (`SOL_PROG_TIME_NS + `SOL_CORE_PERIOD_NS - 1) / `SOL_CORE_PERIOD_NS
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic serial_in,
   output logic serial_out,
   output logic serial_out_en,
   input wire logic [2:0] otp_register_locks,
   input wire logic per_block_protect_select,
   input wire logic legacy_range_protect,
   input wire logic [7:0] query_block,
   output logic array_block_locked,
   output logic busy,
   output logic write_enable_latch
);

   //-------------------------------------------------------------------
   // shared state
   //-------------------------------------------------------------------
   logic [7:0] mem_ff [3][256];
   logic [`SOL_NUM_BLOCKS-1:0] block_lock_ff;
   logic busy_ff;
   logic wel_ff;
   logic blk_locked_ff;
   sol_pkg::sol_rec_t rec_ff;
   sol_pkg::sol_wr_t xfer_ff;
   logic tog_ff;
   localparam logic [31:0] SFDP_SIG = `SOL_SFDP_SIG;

   function automatic logic [2:0] sec_sel(input logic [23:0] a);
      // bit 2 marks a valid register, bits 1..0 its index
      sec_sel = 3'h0;
      if (a[23:16] == 8'h00)
      begin
         case (a[15:8])
            `SOL_SEL_REG1: sec_sel = 3'h4;
            `SOL_SEL_REG2: sec_sel = 3'h5;
            `SOL_SEL_REG3: sec_sel = 3'h6;
            default: sec_sel = 3'h0;
         endcase
      end
   endfunction

   //-------------------------------------------------------------------
   // link domain: shift in, count edges, record the command
   //-------------------------------------------------------------------
   // select high clears the frame state at once; sck is idle then
   wire link_rst = rst | spi_cs_n;
   logic [5:0] cnt_ff;
   logic [31:0] sh_ff;
   logic [2:0] bitpos_ff;
   logic [7:0] baddr_ff;
   logic busy_l1_ff;
   logic busy_l2_ff;
   logic [5:0] nxt_cnt;
   logic [31:0] sh_in;
   logic [5:0] data_start;
   logic in_data;
   logic rd_ok;
   logic [7:0] rd_byte;
   logic [2:0] rd_sel;

   always_comb
   begin
      nxt_cnt = (cnt_ff == `SOL_CNT_MAX) ? cnt_ff : cnt_ff + 6'h01;
      sh_in = {sh_ff[30:0], serial_in};
      if (rec_ff.op == `SOL_OP_RDLOCK || rec_ff.op == `SOL_OP_PROG)
         data_start = `SOL_ADDR_END;
      else
         data_start = `SOL_DUMMY_END;
      in_data = (cnt_ff >= data_start);
   end

   always_ff @(posedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         cnt_ff <= 6'h00;
         sh_ff <= 32'h00000000;
         bitpos_ff <= 3'h0;
         baddr_ff <= 8'h00;
      end
      else
      begin
         cnt_ff <= nxt_cnt;
         sh_ff <= sh_in;
         if (cnt_ff == `SOL_ADDR_END - 6'h01)
         begin
            baddr_ff <= sh_in[7:0];
            bitpos_ff <= 3'h0;
         end
         else if (in_data)
         begin
            bitpos_ff <= bitpos_ff + 3'h1;
            if (bitpos_ff == 3'h7)
               baddr_ff <= baddr_ff + 8'h01;
         end
      end
   end

   // record and handover words survive select high for the core to read
   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         rec_ff <= '{op: 8'h00, addr: 24'h000000, len: sol_pkg::SOL_LEN_NONE};
      end
      else
      begin
         case (cnt_ff)
            6'h00: rec_ff.len <= sol_pkg::SOL_LEN_NONE;
            `SOL_OP_END - 6'h01:
            begin
               rec_ff.op <= sh_in[7:0];
               rec_ff.len <= sol_pkg::SOL_LEN_OP;
            end
            `SOL_OP_END: rec_ff.len <= sol_pkg::SOL_LEN_NONE;
            `SOL_ADDR_END - 6'h01:
            begin
               rec_ff.addr <= sh_in[23:0];
               rec_ff.len <= sol_pkg::SOL_LEN_ADDR;
            end
            `SOL_ADDR_END: rec_ff.len <= sol_pkg::SOL_LEN_NONE;
            default: rec_ff.len <= rec_ff.len;
         endcase
      end
   end

   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         xfer_ff <= '{addr: 8'h00, data: 8'h00};
         tog_ff <= 1'b0;
      end
      else if (!spi_cs_n && in_data && bitpos_ff == 3'h7 &&
               rec_ff.op == `SOL_OP_PROG)
      begin
         // each full data byte is handed over with a toggle
         xfer_ff <= '{addr: baddr_ff, data: sh_in[7:0]};
         tog_ff <= ~tog_ff;
      end
   end

   always_ff @(posedge spi_sck or posedge rst)
   begin
      if (rst)
      begin
         busy_l1_ff <= 1'b0;
         busy_l2_ff <= 1'b0;
      end
      else
      begin
         busy_l1_ff <= busy_ff;
         busy_l2_ff <= busy_l1_ff;
      end
   end

   // array and lock bits are static while a read frame runs, so the
   // link reads them directly instead of copying whole words across
   always_comb
   begin
      rd_sel = sec_sel(rec_ff.addr);
      rd_byte = `SOL_ERASED;
      rd_ok = 1'b0;
      case (rec_ff.op)
         `SOL_OP_SFDP:
         begin
            rd_ok = 1'b1;
            if (baddr_ff[7:2] == 6'h00)
               rd_byte = SFDP_SIG[{baddr_ff[1:0], 3'h0} +: 8];
         end
         `SOL_OP_READ:
         begin
            rd_ok = !busy_l2_ff;
            if (rd_sel[2])
               rd_byte = mem_ff[rd_sel[1:0]][baddr_ff];
         end
         `SOL_OP_RDLOCK:
         begin
            rd_ok = 1'b1;
            rd_byte = {7'h00, block_lock_ff[rec_ff.addr[23:16]]};
         end
         default:
         begin
            rd_ok = 1'b0;
            rd_byte = `SOL_ERASED;
         end
      endcase
   end

   logic sout_ff;
   logic soen_ff;

   always_ff @(negedge spi_sck or posedge link_rst)
   begin
      if (link_rst)
      begin
         sout_ff <= 1'b0;
         soen_ff <= 1'b0;
      end
      else if (in_data && rd_ok)
      begin
         sout_ff <= rd_byte[3'h7 - bitpos_ff];
         soen_ff <= 1'b1;
      end
      else
      begin
         sout_ff <= 1'b0;
         soen_ff <= 1'b0;
      end
   end

   //-------------------------------------------------------------------
   // core domain: crossings
   //-------------------------------------------------------------------
   logic cs_s1_ff;
   logic cs_s2_ff;
   logic cs_s3_ff;
   logic tg_s1_ff;
   logic tg_s2_ff;
   logic tg_s3_ff;

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         cs_s1_ff <= 1'b1;
         cs_s2_ff <= 1'b1;
         cs_s3_ff <= 1'b1;
         tg_s1_ff <= 1'b0;
         tg_s2_ff <= 1'b0;
         tg_s3_ff <= 1'b0;
      end
      else
      begin
         cs_s1_ff <= spi_cs_n;
         cs_s2_ff <= cs_s1_ff;
         cs_s3_ff <= cs_s2_ff;
         tg_s1_ff <= tog_ff;
         tg_s2_ff <= tg_s1_ff;
         tg_s3_ff <= tg_s2_ff;
      end
   end

   //-------------------------------------------------------------------
   // core domain: command decisions
   //-------------------------------------------------------------------
   sol_pkg::sol_job_t job_ff;
   logic [23:0] job_cnt_ff;
   logic [1:0] job_reg_ff;
   logic prog_hit_ff;
   logic rst_en_ff;
   logic frame_end;
   logic wr_evt;
   logic [2:0] sel;
   logic tgt_ok;
   logic erase_ok;
   logic prog_ok;
   logic lock_ok;
   logic soft_rst;
   logic job_done;
   logic op_end;

   always_comb
   begin
      frame_end = cs_s2_ff & ~cs_s3_ff;
      wr_evt = tg_s2_ff ^ tg_s3_ff;
      sel = sec_sel(rec_ff.addr);
      tgt_ok = sel[2] && !otp_register_locks[sel[1:0]];
      op_end = frame_end && rec_ff.len == sol_pkg::SOL_LEN_OP;
      erase_ok = frame_end && rec_ff.len == sol_pkg::SOL_LEN_ADDR &&
                 rec_ff.op == `SOL_OP_ERASE && !busy_ff && wel_ff && tgt_ok;
      prog_ok = rec_ff.op == `SOL_OP_PROG && !busy_ff && wel_ff &&
                tgt_ok;
      lock_ok = frame_end && rec_ff.len == sol_pkg::SOL_LEN_ADDR &&
                !busy_ff && wel_ff;
      soft_rst = op_end && rec_ff.op == `SOL_OP_RST && rst_en_ff;
      job_done = job_ff != sol_pkg::SOL_JOB_IDLE && job_cnt_ff == 24'h000000;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         rst_en_ff <= 1'b0;
      else if (frame_end)
         rst_en_ff <= op_end && rec_ff.op == `SOL_OP_RSTEN;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         prog_hit_ff <= 1'b0;
      else if (frame_end)
         prog_hit_ff <= 1'b0;
      else if (wr_evt && prog_ok)
         prog_hit_ff <= 1'b1;
   end

   //-------------------------------------------------------------------
   // core domain: self-timed cycles
   //-------------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         job_ff <= sol_pkg::SOL_JOB_IDLE;
         job_cnt_ff <= 24'h000000;
         job_reg_ff <= 2'h0;
         busy_ff <= 1'b0;
      end
      else if (soft_rst)
      begin
         job_ff <= sol_pkg::SOL_JOB_IDLE;
         busy_ff <= 1'b0;
      end
      else
      begin
         case (job_ff)
            sol_pkg::SOL_JOB_IDLE:
            begin
               if (erase_ok)
               begin
                  job_ff <= sol_pkg::SOL_JOB_ERASE;
                  job_cnt_ff <= ERASE_CYCLES[23:0] - 24'h000001;
                  job_reg_ff <= sel[1:0];
                  busy_ff <= 1'b1;
               end
               // a byte landing with the frame end still starts the cycle
               else if (frame_end && (prog_hit_ff || (wr_evt && prog_ok)))
               begin
                  job_ff <= sol_pkg::SOL_JOB_PROG;
                  job_cnt_ff <= PROG_CYCLES[23:0] - 24'h000001;
                  busy_ff <= 1'b1;
               end
            end
            sol_pkg::SOL_JOB_ERASE, sol_pkg::SOL_JOB_PROG:
            begin
               if (job_done)
               begin
                  job_ff <= sol_pkg::SOL_JOB_IDLE;
                  busy_ff <= 1'b0;
               end
               else
                  job_cnt_ff <= job_cnt_ff - 24'h000001;
            end
            default:
            begin
               job_ff <= sol_pkg::SOL_JOB_IDLE;
               busy_ff <= 1'b0;
            end
         endcase
      end
   end

   //-------------------------------------------------------------------
   // core domain: storage
   //-------------------------------------------------------------------
   // the erase lands at the end of its cycle; a cut-off erase leaves
   // the register as it was
   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
      begin
         for (int r = 0; r < 3; r++)
            for (int b = 0; b < 256; b++)
               mem_ff[r][b] <= `SOL_ERASED;
      end
      else if (job_done && job_ff == sol_pkg::SOL_JOB_ERASE && !soft_rst)
      begin
         for (int b = 0; b < 256; b++)
            mem_ff[job_reg_ff][b] <= `SOL_ERASED;
      end
      else if (wr_evt && prog_ok)
      begin
         // programming only clears bits, so only erased bits take data
         mem_ff[sel[1:0]][xfer_ff.addr] <=
            mem_ff[sel[1:0]][xfer_ff.addr] & xfer_ff.data;
      end
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         wel_ff <= 1'b0;
      else if (soft_rst)
         wel_ff <= 1'b0;
      else if (op_end && rec_ff.op == `SOL_OP_WREN && !busy_ff)
         wel_ff <= 1'b1;
      else if (op_end && rec_ff.op == `SOL_OP_WRDI && !busy_ff)
         wel_ff <= 1'b0;
      else if (job_done)
         wel_ff <= 1'b0;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         block_lock_ff <= '1;
      else if (soft_rst)
         block_lock_ff <= '1;
      else if (lock_ok && rec_ff.op == `SOL_OP_LOCK)
         block_lock_ff[rec_ff.addr[23:16]] <= 1'b1;
      else if (lock_ok && rec_ff.op == `SOL_OP_UNLOCK)
         block_lock_ff[rec_ff.addr[23:16]] <= 1'b0;
   end

   always_ff @(posedge core_clk or posedge rst)
   begin
      if (rst)
         blk_locked_ff <= 1'b1;
      else if (per_block_protect_select)
         blk_locked_ff <= block_lock_ff[query_block];
      else
         blk_locked_ff <= legacy_range_protect;
   end

   assign serial_out = sout_ff;
   assign serial_out_en = soen_ff;
   assign busy = busy_ff;
   assign write_enable_latch = wel_ff;
   assign array_block_locked = blk_locked_ff;

endmodule // sol_cmd_core

// ### sol_cmd_core_sva.sv
// port assertions for the security register and block lock commands
`timescale 1ns/1ns
module sol_cmd_core_sva #(
   parameter int ERASE_CYCLES = 20,
   parameter int PROG_CYCLES = 20
) (
   input wire logic core_clk,
   input wire logic rst,
   input wire logic spi_sck,
   input wire logic spi_cs_n,
   input wire logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en,
   input wire logic [2:0] otp_register_locks,
   input wire logic per_block_protect_select,
   input wire logic legacy_range_protect,
   input wire logic [7:0] query_block,
   input wire logic array_block_locked,
   input wire logic busy,
   input wire logic write_enable_latch
);
   localparam int MAX_RUN =
      (ERASE_CYCLES > PROG_CYCLES) ? ERASE_CYCLES : PROG_CYCLES;
   logic [31:0] busy_run_ff;
   logic [3:0] since_rst_ff;
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);
   //----------
   // helpers
   //----------
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         busy_run_ff <= 32'h0;
      else if (busy)
         busy_run_ff <= busy_run_ff + 32'h1;
      else
         busy_run_ff <= 32'h0;
   // saturates so the early-after-reset window stays short
   always_ff @(posedge core_clk or posedge rst)
      if (rst)
         since_rst_ff <= 4'h0;
      else if (since_rst_ff != 4'hf)
         since_rst_ff <= since_rst_ff + 4'h1;
   sequence s_cycle_end;
      busy ##1 !busy;
   endsequence
   sequence s_select_high;
      $past(spi_cs_n, 2) && $past(spi_cs_n);
   endsequence
   //----------
   // checks
   //----------
   a_busy_bound: assert property (busy |-> busy_run_ff < MAX_RUN)
      else $error("busy held beyond the longest cycle");
   a_wel_after_cycle: assert property (
      s_cycle_end |-> ##[0:1] !write_enable_latch)
      else $error("write enable latch kept after cycle end");
   a_start_needs_wel: assert property (
      $rose(busy) |-> write_enable_latch)
      else $error("cycle started without write enable");
   a_start_after_frame: assert property (
      $rose(busy) |-> s_select_high)
      else $error("cycle started inside a frame");
   a_wel_set_idle: assert property (
      $rose(write_enable_latch) |-> !busy && !$past(busy))
      else $error("write enable taken while busy");
   a_range_view: assert property (
      since_rst_ff != 4'h0 && !$past(per_block_protect_select)
      |-> array_block_locked == $past(legacy_range_protect))
      else $error("range protection not followed");
   a_locks_at_reset: assert property (
      since_rst_ff inside {[4'h1:4'h7]} && $past(per_block_protect_select)
      |-> array_block_locked)
      else $error("block not locked after reset");
   a_out_quiet: assert property (spi_cs_n |-> !serial_out_en)
      else $error("output driven while deselected");
   a_out_low_idle: assert property (!serial_out_en |-> !serial_out)
      else $error("output data not low while idle");
endmodule // sol_cmd_core_sva

bind sol_cmd_core sol_cmd_core_sva #(
   .ERASE_CYCLES(ERASE_CYCLES),
   .PROG_CYCLES(PROG_CYCLES)
) u_sva (
   .core_clk(core_clk), .rst(rst), .spi_sck(spi_sck),
   .spi_cs_n(spi_cs_n), .serial_in(serial_in), .serial_out(serial_out),
   .serial_out_en(serial_out_en),
   .otp_register_locks(otp_register_locks),
   .per_block_protect_select(per_block_protect_select),
   .legacy_range_protect(legacy_range_protect),
   .query_block(query_block), .array_block_locked(array_block_locked),
   .busy(busy), .write_enable_latch(write_enable_latch)
);

// ### sol_defs.svh
// constants for the security register and block lock command block
//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
// Operation
// - parameter table read: 5Ah, address, dummies, output
// - security erase 44h needs write enable latch set
// - register select by address bits 15..8
// - erase runs only if select rises after address
// - erase self-timed, busy held high meanwhile
// - erase completion clears write enable latch
// - locked security register ignores erase and program
// - security program 42h needs write enable latch
// - security read 48h, address, dummies, data out
// - read address increments, wraps within register
// - nonzero upper address reads undefined data
// - security read while busy is ignored
// - protect select chooses block locks or ranges
// - block locks volatile, all locked after reset
// - block lock 36h sets bit with latch set
// - block unlock 39h clears bit with latch set
// - lock read 3Dh returns lock in bit zero
// - reset enable then reset restores lock defaults
`ifndef SOL_DEFS_SVH
`define SOL_DEFS_SVH

//----------------------------------------------------------------------
// opcodes
//----------------------------------------------------------------------
`define SOL_OP_SFDP 8'h5a
`define SOL_OP_ERASE 8'h44
`define SOL_OP_PROG 8'h42
`define SOL_OP_READ 8'h48
`define SOL_OP_LOCK 8'h36
`define SOL_OP_UNLOCK 8'h39
`define SOL_OP_RDLOCK 8'h3d
`define SOL_OP_WREN 8'h06
`define SOL_OP_WRDI 8'h04
`define SOL_OP_RSTEN 8'h66
`define SOL_OP_RST 8'h99

//----------------------------------------------------------------------
// frame bit positions (rising edges counted from select low)
//----------------------------------------------------------------------
`define SOL_OP_END 6'h08
`define SOL_ADDR_END 6'h20
`define SOL_DUMMY_END 6'h28
`define SOL_CNT_MAX 6'h3f

//----------------------------------------------------------------------
// security register selects and table content
//----------------------------------------------------------------------
`define SOL_SEL_REG1 8'h10
`define SOL_SEL_REG2 8'h20
`define SOL_SEL_REG3 8'h30
`define SOL_ERASED 8'hff
`define SOL_SFDP_SIG 32'h50444653
`define SOL_NUM_BLOCKS 256

//----------------------------------------------------------------------
// timing
//----------------------------------------------------------------------
`define SOL_CORE_PERIOD_NS 4
`define SOL_ERASE_TIME_NS 1000000
`define SOL_PROG_TIME_NS 400000

`endif

// ### sol_host_model.sv
// host serial controller model driving select, clock and data
`timescale 1ns/1ns
module sol_host_model (
   output logic spi_sck,
   output logic spi_cs_n,
   output logic serial_in,
   input wire logic serial_out,
   input wire logic serial_out_en
);
   initial
   begin
      spi_sck = 1'b0;
      spi_cs_n = 1'b1;
      serial_in = 1'b0;
   end
   // clock idles low between frames; rdata keeps the last 16 samples
   task automatic frame(input logic [7:0] op, input logic [23:0] addr,
      input int nbits, input logic [15:0] wdata,
      output logic [15:0] rdata, output logic en_seen);
      logic [47:0] word;
      word = {op, addr, wdata};
      rdata = 16'h0;
      en_seen = 1'b0;
      spi_cs_n = 1'b0;
      for (int k = 0; k < nbits; k++)
      begin
         serial_in = (k < 48) ? word[47 - k] : ~serial_in;
         #7 spi_sck = 1'b1;
         // a line not driven reads back as the inverse of its last value
         rdata = {rdata[14:0], serial_out_en ? serial_out : ~serial_out};
         en_seen = en_seen | serial_out_en;
         #8 spi_sck = 1'b0;
      end
      #7 spi_cs_n = 1'b1;
      serial_in = ~serial_in;
      #20;
   endtask
endmodule // sol_host_model

// ### sol_pkg.sv
// types shared by the security register and block lock command block
package sol_pkg;

   // length class of the last frame seen on the link
   typedef enum logic [1:0] {
      SOL_LEN_NONE,
      SOL_LEN_OP,
      SOL_LEN_ADDR
   } sol_len_t;

   // command record captured at the link, read by the core at frame end
   typedef struct packed {
      logic [7:0] op;
      logic [23:0] addr;
      sol_len_t len;
   } sol_rec_t;

   // one programmed byte handed from link to core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] data;
   } sol_wr_t;

   typedef enum logic [1:0] {
      SOL_JOB_IDLE,
      SOL_JOB_ERASE,
      SOL_JOB_PROG
   } sol_job_t;

endpackage
